// file: rtl/option_return_from_irq_decode.sv
`timescale 1ns/1ps
// decode and execute of the option load and the return from interrupt
module option_return_from_irq_decode (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic insn_valid_i,
  input wire logic [13:0] insn_i,
  input wire logic [7:0] w_i,
  input wire op_decode_pkg::file_wr_t file_wr_i,
  input wire logic [6:0] file_rd_addr_i,
  input wire op_decode_pkg::call_req_t call_i,
  input wire logic [12:0] pc_next_i,
  input wire logic [7:0] status_i,
  output logic [7:0] file_rd_data_o,
  output logic [7:0] option_o,
  output logic [7:0] irq_control_o,
  output logic global_irq_enable_o,
  output logic [12:0] pc_o,
  output logic pc_load_o,
  output logic flush_o,
  output logic busy_o,
  output logic [7:0] status_o
);
  typedef enum logic [0:0] {ST_RUN, ST_FLUSH} state_t;

  // one opcode compare per instruction, shared by decode and checks
  function automatic logic is_opc(input logic [13:0] w, input logic [13:0] opc);
    return w == opc;
  endfunction

  state_t state_q, state_d;
  logic [7:0] option_q, option_d;
  logic [7:0] irqc_q, irqc_d;
  logic [12:0] pc_q, pc_d;
  logic pc_load_q, pc_load_d;
  logic flush_q, flush_d;
  logic busy_q, busy_d;
  logic [7:0] rd_q, rd_d;
  logic [7:0] status_q, status_d;
  logic [12:0] stack_top;
  logic do_opt, do_ret, pop;

  // a word arriving during the flush cycle is the stale prefetch and is dropped
  assign do_opt = insn_valid_i && state_q == ST_RUN &&
                  is_opc(insn_i, op_decode_pkg::OPC_OPTION_LOAD);
  assign do_ret = insn_valid_i && state_q == ST_RUN &&
                  is_opc(insn_i, op_decode_pkg::OPC_RETURN_FROM_IRQ);
  assign pop = do_ret; // [RL3]

  ret_stack #(
    .DEPTH(op_decode_pkg::STACK_DEPTH),
    .PTR_W(op_decode_pkg::STACK_PTR_W),
    .ADDR_W(op_decode_pkg::PC_W)
  ) u_stack (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(call_i.push),
    .pop_i(pop),
    .push_addr_i(call_i.addr),
    .top_o(stack_top)
  );

  // execute: option load wins over a file write in the same cycle
  always_comb begin
    state_d = ST_RUN;
    option_d = option_q;
    irqc_d = irqc_q;
    pc_d = pc_next_i;
    pc_load_d = 1'b0;
    flush_d = 1'b0;
    busy_d = 1'b0;
    status_d = status_i; // [RL6] flags pass through untouched
    if (file_wr_i.wr && file_wr_i.addr == op_decode_pkg::ADDR_OPTION) begin
      option_d = file_wr_i.data; // [RL2]
    end
    if (file_wr_i.wr && file_wr_i.addr == op_decode_pkg::ADDR_IRQ_CONTROL) begin
      irqc_d = file_wr_i.data;
    end
    if (do_opt) begin
      option_d = w_i; // [RL1] single cycle, no flush [RL6]
    end
    if (do_ret) begin
      pc_d = stack_top; // [RL3]
      pc_load_d = 1'b1;
      flush_d = 1'b1; // [RL5]
      busy_d = 1'b1; // [RL5]
      state_d = ST_FLUSH; // [RL5]
      irqc_d[op_decode_pkg::GLOBAL_IRQ_ENABLE_BIT] = 1'b1; // [RL4] set wins over a file write
    end
    // read data is registered, so it shows writes made on the same edge
    rd_d = 8'h00;
    case (file_rd_addr_i)
      op_decode_pkg::ADDR_OPTION: rd_d = option_d; // [RL2]
      op_decode_pkg::ADDR_IRQ_CONTROL: rd_d = irqc_d;
      default: rd_d = 8'h00;
    endcase
  end

  // one register stage for all execute state; a low clock enable holds everything
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
      option_q <= op_decode_pkg::OPTION_RST;
      irqc_q <= op_decode_pkg::IRQ_CONTROL_RST;
      pc_q <= op_decode_pkg::PC_RST;
      pc_load_q <= 1'b0;
      flush_q <= 1'b0;
      busy_q <= 1'b0;
      rd_q <= 8'h00;
      status_q <= op_decode_pkg::STATUS_RST;
    end else if (ce_i) begin
      state_q <= state_d;
      option_q <= option_d;
      irqc_q <= irqc_d;
      pc_q <= pc_d;
      pc_load_q <= pc_load_d;
      flush_q <= flush_d;
      busy_q <= busy_d;
      rd_q <= rd_d;
      status_q <= status_d;
    end
  end

  // outputs come straight from their flops; no decode sits between flop and pin
  assign option_o = option_q;
  assign irq_control_o = irqc_q;
  assign global_irq_enable_o = irqc_q[op_decode_pkg::GLOBAL_IRQ_ENABLE_BIT];
  assign pc_o = pc_q;
  assign pc_load_o = pc_load_q;
  assign flush_o = flush_q;
  assign busy_o = busy_q;
  assign file_rd_data_o = rd_q;
  assign status_o = status_q;

  // a return accepted on this edge, the flush cycle behind it and the resumed run
  sequence s_ret_taken;
    ce_i && do_ret;
  endsequence

  sequence s_flush_cycle;
    busy_o && flush_o && pc_load_o;
  endsequence

  sequence s_resume;
    !busy_o && !flush_o && !pc_load_o;
  endsequence

  // the dedicated load copies the whole working register in one cycle
  AST_OPT_LOAD: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
    ce_i && do_opt |=> option_o == $past(w_i))
    else $error("option register not loaded from working register");

  // ordinary file writes reach the option register when no load competes
  AST_OPT_FILE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL2]
    ce_i && !do_opt && file_wr_i.wr && file_wr_i.addr == op_decode_pkg::ADDR_OPTION
    |=> option_o == $past(file_wr_i.data))
    else $error("file write to option register lost");

  // the redirect target is the stack top as it stood before the pop
  AST_RET_PC: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
    s_ret_taken |=> pc_load_o && pc_o == $past(stack_top))
    else $error("pc not loaded from stack top");

  // interrupts come back on at the same edge as the redirect
  AST_RET_IRQ_EN: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
    s_ret_taken |=> global_irq_enable_o)
    else $error("global interrupt enable not set");

  // the word behind a return is dropped, then the core runs again
  AST_RET_TWO: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
    s_ret_taken ##1 ce_i |-> busy_o && flush_o && !do_ret && !do_opt ##1 !busy_o)
    else $error("return did not take two cycles");

  // neither instruction may disturb the arithmetic flags
  AST_FLAGS: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
    ce_i && (do_ret || do_opt) |=> status_o == $past(status_i))
    else $error("status flags altered");

  // the option load must never stall the fetch
  AST_OPT_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
    ce_i && do_opt |=> !busy_o && !flush_o)
    else $error("option load stalled the pipeline");

  // the flush cycle carries all three pulses together
  AST_RET_FLUSH: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
    s_ret_taken |=> s_flush_cycle)
    else $error("return flush cycle incomplete");

  // pulses stand for one enabled cycle only; a stuck redirect would loop the core
  AST_PULSE_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
    ce_i && pc_load_o |=> s_resume)
    else $error("redirect pulse stood too long");

  // the prefetched word in the flush cycle must not reach the option register
  AST_FLUSH_DROP: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
    ce_i && busy_o && !(file_wr_i.wr && file_wr_i.addr == op_decode_pkg::ADDR_OPTION)
    |=> option_o == $past(option_o))
    else $error("flushed word changed the option register");

  // only a return redirects; otherwise pc follows the sequential value
  AST_SEQ_PC: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
    ce_i && !do_ret |=> pc_o == $past(pc_next_i) && !pc_load_o)
    else $error("pc redirected without a return");

  // reads of the option address see the register as it stands after this edge
  AST_OPT_READ: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL2]
    ce_i && file_rd_addr_i == op_decode_pkg::ADDR_OPTION |=> file_rd_data_o == option_o)
    else $error("option read data differs from register");

  // software may clear the enable again when no return competes
  AST_IRQ_EN_FILE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
    ce_i && !do_ret && file_wr_i.wr && file_wr_i.addr == op_decode_pkg::ADDR_IRQ_CONTROL
    |=> irq_control_o == $past(file_wr_i.data))
    else $error("file write to interrupt control lost");

  // apart from the option load and a file write to it, no other instruction or idle cycle may touch the option register
  AST_OPT_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
    ce_i && !do_opt && !(file_wr_i.wr && file_wr_i.addr == op_decode_pkg::ADDR_OPTION)
    |=> $stable(option_o))
    else $error("option register changed without a load");

  // a low clock enable freezes every register, a pending flush included
  AST_FREEZE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
    !ce_i |=> $stable(option_o) && $stable(pc_o) && $stable(busy_o) && $stable(status_o))
    else $error("state moved while clock enable was low");
endmodule

// file: rtl/op_decode_pkg.sv
// Overview of operation
// RL1: an instruction word equal to the option-load opcode copies all of the working register into the prescaler configuration register.
// RL2: the prescaler configuration register is also read and written through ordinary file-register addressing.
// RL3: the return-from-interrupt opcode pops the return stack and loads the program counter from the old stack top.
// RL4: return-from-interrupt sets global_irq_enable, bit 7 of irq_control_reg, to one.
// RL5: return-from-interrupt takes two instruction cycles, the prefetched word being flushed.
// RL6: both instructions are one word, leave the zero, carry and digit-carry flags alone, and the option load takes one cycle.
package op_decode_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned STACK_PTR_W = 3;
  localparam logic [13:0] OPC_OPTION_LOAD = 14'h0062;
  localparam logic [13:0] OPC_RETURN_FROM_IRQ = 14'h0009;
  localparam logic [6:0] ADDR_OPTION = 7'h01;
  localparam logic [6:0] ADDR_IRQ_CONTROL = 7'h0B;
  localparam int unsigned GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam int unsigned RETURN_CYCLES = 2;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  typedef struct packed {
    logic push;
    logic [12:0] addr;
  } call_req_t;
endpackage

// file: rtl/ret_stack.sv
`timescale 1ns/1ps
// hardware return stack; circular, so overflow silently overwrites the oldest entry
module ret_stack #(
  parameter int unsigned DEPTH = op_decode_pkg::STACK_DEPTH,
  parameter int unsigned PTR_W = op_decode_pkg::STACK_PTR_W,
  parameter int unsigned ADDR_W = op_decode_pkg::PC_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [ADDR_W-1:0] push_addr_i,
  output logic [ADDR_W-1:0] top_o
);
  logic [ADDR_W-1:0] mem_q [DEPTH];
  logic [ADDR_W-1:0] mem_d [DEPTH];
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;

  // push writes above the pointer, pop steps the pointer back down
  always_comb begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    if (push_i) begin
      ptr_d = ptr_q + PTR_W'(1);
      mem_d[ptr_d] = push_addr_i;
    end else if (pop_i) begin
      ptr_d = ptr_q - PTR_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ptr_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce_i) begin
      ptr_q <= ptr_d;
      mem_q <= mem_d;
    end
  end

  assign top_o = mem_q[ptr_q];
endmodule

// file: test/prog_mem.sv
`timescale 1ns/1ps
// program store feeding the decoder; only a handful of words are needed
module prog_mem (
  input wire logic [12:0] addr_i,
  output logic [13:0] insn_o
);
  logic [13:0] mem [0:3];
  // fixed image: nop, option load, return, nop
  initial begin
    mem[0] = 14'h0000;
    mem[1] = op_decode_pkg::OPC_OPTION_LOAD;
    mem[2] = op_decode_pkg::OPC_RETURN_FROM_IRQ;
    mem[3] = 14'h0000;
  end
  // asynchronous read keeps fetch timing out of the decoder checks
  assign insn_o = mem[addr_i[1:0]];
endmodule

// file: test/cpu_option_return_from_irq_decode_bench.sv
`timescale 1ns/1ps
module cpu_option_return_from_irq_decode_bench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic valid = 1'b0;
  logic ce = 1'b1;
  logic [12:0] fa = 13'h0000;
  logic [13:0] insn;
  logic [7:0] w = 8'h00;
  op_decode_pkg::file_wr_t fw = '0;
  logic [6:0] ra = 7'h00;
  op_decode_pkg::call_req_t cr = '0;
  logic [7:0] st = 8'h5A;
  logic [7:0] rd, opt, irq, sto;
  logic irq_en, pcl, fl, busy;
  logic [12:0] pc;
  int err_total = 0;
  int check_count = 0;
  // 200 MHz core clock
  always #2.5 ref_clk_i = ~ref_clk_i;
  prog_mem pm (.addr_i(fa), .insn_o(insn));
  option_return_from_irq_decode dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .insn_valid_i(valid), .insn_i(insn), .w_i(w), .file_wr_i(fw), .file_rd_addr_i(ra),
    .call_i(cr), .pc_next_i(13'h0100), .status_i(st), .file_rd_data_o(rd), .option_o(opt),
    .irq_control_o(irq), .global_irq_enable_o(irq_en), .pc_o(pc), .pc_load_o(pcl),
    .flush_o(fl), .busy_o(busy), .status_o(sto));
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk(n, {12'h000, e}, {12'h000, g});
  endtask
  // inputs move 1 ns after the edge so sampling never races
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic issue(input logic [12:0] a);
    fa = a;
    valid = 1'b1;
    step();
  endtask
  task automatic idle();
    valid = 1'b0;
    fw = '0;
    step();
  endtask
  task automatic t_option();
    w = 8'h4F;
    issue(13'h0001);
    chk("option", 8'h4F, opt);
    chk("status", 8'h5A, sto);
    w = 8'hA5;
    fw = '{1'b1, op_decode_pkg::ADDR_OPTION, 8'h11};
    issue(13'h0001);
    chk("option b2b", 8'hA5, opt);
    chk_bit("pc load", 1'b0, pcl);
    idle();
    fw = '{1'b1, op_decode_pkg::ADDR_OPTION, 8'h3C};
    ra = op_decode_pkg::ADDR_OPTION;
    step();
    fw = '0;
    chk("option file", 8'h3C, opt);
    step();
    chk("read back", 8'h3C, rd);
    $display("test option done");
  endtask
  task automatic t_return();
    cr = '{1'b1, 13'h0ABC};
    step();
    cr = '{1'b1, 13'h1234};
    step();
    cr = '0;
    chk_bit("irq en idle", 1'b0, irq_en);
    issue(13'h0002);
    chk("pc", 13'h1234, pc);
    chk_bit("load", 1'b1, pcl);
    chk_bit("flush", 1'b1, fl);
    chk_bit("busy", 1'b1, busy);
    chk_bit("irq en", 1'b1, irq_en);
    chk("status", 8'h5A, sto);
    w = 8'h77;
    issue(13'h0001);
    chk("option held", 8'h3C, opt);
    chk_bit("busy end", 1'b0, busy);
    idle();
    fw = '{1'b1, op_decode_pkg::ADDR_IRQ_CONTROL, 8'h00};
    step();
    chk_bit("irq en clr", 1'b0, irq_en);
    fw = '{1'b1, op_decode_pkg::ADDR_IRQ_CONTROL, 8'h05};
    issue(13'h0002);
    chk("pc 2", 13'h0ABC, pc);
    chk("irq", 8'h85, irq);
    idle();
    chk("pc seq", 13'h0100, pc);
    $display("test return done");
  endtask
  // clock enable low must freeze every register, a pending flush included
  task automatic t_freeze();
    cr = '{1'b1, 13'h0777};
    fw = '{1'b1, op_decode_pkg::ADDR_IRQ_CONTROL, 8'h00};
    step();
    cr = '{1'b1, 13'h0555};
    fw = '{1'b1, op_decode_pkg::ADDR_IRQ_CONTROL, 8'hFF};
    ce = 1'b0;
    st = 8'h3B;
    issue(13'h0002);
    chk("pc frozen", 13'h0100, pc);
    chk_bit("load frozen", 1'b0, pcl);
    chk("irq frozen", 8'h00, irq);
    chk("status frozen", 8'h5A, sto);
    cr = '0;
    fw = '0;
    ce = 1'b1;
    step();
    chk("pc thaw", 13'h0777, pc);
    chk("irq thaw", 8'h80, irq);
    chk("status thaw", 8'h3B, sto);
    valid = 1'b0;
    ra = op_decode_pkg::ADDR_IRQ_CONTROL;
    ce = 1'b0;
    step();
    chk_bit("busy frozen", 1'b1, busy);
    chk_bit("flush frozen", 1'b1, fl);
    ce = 1'b1;
    step();
    chk_bit("busy thaw", 1'b0, busy);
    chk("irq read", 8'h80, rd);
    st = 8'h5A;
    $display("test freeze done");
  endtask
  // a reset in mid-run must also empty the return stack
  task automatic t_reset();
    cr = '{1'b1, 13'h0999};
    step();
    cr = '0;
    rst_i = 1'b1;
    repeat (2) step();
    chk("pc rst", 13'h0000, pc);
    chk("status rst", 8'h18, sto);
    chk("option rst2", 8'hFF, opt);
    chk_bit("busy rst", 1'b0, busy);
    chk("read rst", 8'h00, rd);
    rst_i = 1'b0;
    issue(13'h0002);
    chk("pc after rst", 13'h0000, pc);
    chk_bit("load after rst", 1'b1, pcl);
    chk_bit("irq en after rst", 1'b1, irq_en);
    idle();
    $display("test reset done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // reset for six cycles, then the scenarios
  initial begin
    repeat (6) step();
    chk("option rst", 8'hFF, opt);
    chk("irq rst", 8'h00, irq);
    rst_i = 1'b0;
    t_option();
    t_return();
    t_freeze();
    t_reset();
    wrap_up();
  end
endmodule
